// *** design/acrb_regs.svh ***
`ifndef ACRB_REGS_SVH
`define ACRB_REGS_SVH

`define ACRB_ADDR_W 5
`define ACRB_ADDR_RESULT_LO 5'h00
`define ACRB_ADDR_RESULT_HI 5'h01
`define ACRB_ADDR_RANGE 5'h02
`define ACRB_ADDR_CONV_CTRL 5'h03
`define ACRB_ADDR_GAIN_CHAN 5'h04

`define ACRB_RESET_BYTE 8'h00
`define ACRB_CTRL_FMT_BIT 5
`define ACRB_CTRL_RBM_HI 3
`define ACRB_CTRL_RBM_LO 2
`define ACRB_CTRL_DIV_HI 1
`define ACRB_CTRL_DIV_LO 0
`define ACRB_GC_BUSY_BIT 7
`define ACRB_GC_GAIN_HI 6
`define ACRB_GC_GAIN_LO 4
`define ACRB_GC_CHAN_HI 3
`define ACRB_GC_CHAN_LO 0
`define ACRB_RANGE_W 6
`define ACRB_RESULT_W 12

`define ACRB_RBM_EXPLICIT 2'h0
`define ACRB_RBM_HIGH_FIRST 2'h1
`define ACRB_RBM_LOW_FIRST 2'h2
`define ACRB_RBM_HIGH_ONLY 2'h3

`define ACRB_START_FALLS 2'h2

`endif

// *** design/acrb_pkg.sv ***
package acrb_pkg;

    typedef logic [2:0] acrb_gain_t;
    typedef logic [3:0] acrb_chan_t;

    typedef enum logic [2:0] {
        CV_IDLE = 3'b001,
        CV_ARM = 3'b010,
        CV_RUN = 3'b100
    } acrb_conv_state_t;

    typedef enum logic [2:0] {
        RB_IDLE = 3'b001,
        RB_FIRST = 3'b010,
        RB_SECOND = 3'b100
    } acrb_rb_state_t;

endpackage : acrb_pkg

// *** design/acrb_clkdiv.sv ***
`timescale 1ns/1ps
`include "acrb_regs.svh"

module acrb_clkdiv (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic converter_clock_in_sync,
    input wire logic [1:0] div_sel,
    output logic divided_conv_clock,
    output logic divided_conv_clock_fall
);
    import acrb_pkg::*;

    logic converter_clock_in_d_r;
    logic [3:0] edge_cnt_r;
    logic [3:0] edge_cnt_nxt;
    logic divided_conv_clock_r;
    logic divided_conv_clock_nxt;
    logic fall_r;
    logic fall_nxt;

    // Each converter clock edge is a half period; counter bit k halves k times
    always_comb begin
        edge_cnt_nxt = edge_cnt_r;
        if (converter_clock_in_sync != converter_clock_in_d_r) begin
            edge_cnt_nxt = 4'(edge_cnt_r + 4'h1);
        end
        if (div_sel == 2'h0) begin
            divided_conv_clock_nxt = converter_clock_in_sync;
        end else begin
            divided_conv_clock_nxt = edge_cnt_nxt[div_sel];
        end
        fall_nxt = divided_conv_clock_r & ~divided_conv_clock_nxt;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            converter_clock_in_d_r <= 1'b0;
            edge_cnt_r <= 4'h0;
            divided_conv_clock_r <= 1'b0;
            fall_r <= 1'b0;
        end else begin
            converter_clock_in_d_r <= converter_clock_in_sync;
            edge_cnt_r <= edge_cnt_nxt;
            divided_conv_clock_r <= divided_conv_clock_nxt;
            fall_r <= fall_nxt;
        end
    end

    assign divided_conv_clock = divided_conv_clock_r;
    assign divided_conv_clock_fall = fall_r;

endmodule : acrb_clkdiv

// *** design/acrb_top.sv ***
`timescale 1ns/1ps
`include "acrb_regs.svh"

module acrb_top #(
    parameter int RESULT_W = `ACRB_RESULT_W
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [`ACRB_ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic DIRECT_START,
    input wire logic [7:0] DIRECT_BYTE,
    input wire logic CONVERTER_CLOCK_IN,
    input wire logic [RESULT_W-1:0] SAR_RESULT,
    input wire logic SAR_DONE,
    input wire logic [`ACRB_RANGE_W-1:0] RANGE_CMP,
    output logic DIVIDED_CONV_CLOCK,
    output logic CONV_START,
    output logic CONV_BUSY,
    output acrb_pkg::acrb_gain_t GAIN_CODE,
    output logic [4:0] GAIN_FACTOR,
    output acrb_pkg::acrb_chan_t CHANNEL_CODE,
    output logic SINGLE_ENDED_SEL,
    output logic POLARITY_SWAP,
    output logic [7:0] POS_LINE_SEL,
    output logic [7:0] NEG_LINE_SEL,
    output logic OUTPUT_FORMAT_SEL,
    output logic OVER_RANGE_FLAG,
    output logic READBACK_VALID,
    output logic [7:0] READBACK_DATA
);
    import acrb_pkg::*;

    if (RESULT_W != `ACRB_RESULT_W) begin : g_bad_width
        $error("acrb_top: result width must be 12");
    end

    // Reset release synchroniser
    logic rst_s1_r;
    logic rst_s2_r;
    logic rst_n;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign rst_n = rst_s2_r;

    // Pin synchronisers: converter clock and analog comparator levels
    logic converter_clock_in_s1_r;
    logic converter_clock_in_s2_r;
    logic [`ACRB_RANGE_W-1:0] cmp_s1_r;
    logic [`ACRB_RANGE_W-1:0] cmp_s2_r;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            converter_clock_in_s1_r <= 1'b0;
            converter_clock_in_s2_r <= 1'b0;
            cmp_s1_r <= '0;
            cmp_s2_r <= '0;
        end else begin
            converter_clock_in_s1_r <= CONVERTER_CLOCK_IN;
            converter_clock_in_s2_r <= converter_clock_in_s1_r;
            cmp_s1_r <= RANGE_CMP;
            cmp_s2_r <= cmp_s1_r;
        end
    end

    // Register state
    logic fmt_r, fmt_nxt;
    logic [1:0] rbm_r, rbm_nxt;
    logic [1:0] div_r, div_nxt;
    acrb_gain_t gain_r, gain_nxt;
    acrb_chan_t chan_r, chan_nxt;
    logic [RESULT_W-1:0] result_r, result_nxt;
    logic [`ACRB_RANGE_W-1:0] range_r, range_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic start_req;

    // Conversion sequencer state
    acrb_conv_state_t cv_r, cv_nxt;
    logic [1:0] falls_r, falls_nxt;
    logic start_r, start_nxt;
    logic busy_r, busy_nxt;

    // Read-back state
    acrb_rb_state_t rb_r, rb_nxt;
    logic rb_low_first_r, rb_low_first_nxt;
    logic rb_valid_r, rb_valid_nxt;
    logic [7:0] rb_data_r, rb_data_nxt;

    // Decoded from the next codes so they move together with the code outputs
    logic [4:0] gfac_r, gfac_nxt;
    logic [7:0] pos_r, pos_nxt;
    logic [7:0] neg_r, neg_nxt;
    logic swap_r, swap_nxt;
    logic ovr_r, ovr_nxt;

    logic divided_conv_clock, divided_conv_clock_fall;
    logic [7:0] byte_hi, byte_lo;

    acrb_clkdiv u_clkdiv (
        .clk(CLK),
        .rst_n(rst_n),
        .converter_clock_in_sync(converter_clock_in_s2_r),
        .div_sel(div_r),
        .divided_conv_clock(divided_conv_clock),
        .divided_conv_clock_fall(divided_conv_clock_fall)
    );

    assign byte_hi = result_r[RESULT_W-1 -: 8];
    assign byte_lo = {result_r[3:0], 3'h0, |range_r};

    // Register writes and result capture
    always_comb begin
        fmt_nxt = fmt_r;
        rbm_nxt = rbm_r;
        div_nxt = div_r;
        gain_nxt = gain_r;
        chan_nxt = chan_r;
        result_nxt = result_r;
        range_nxt = range_r;
        start_req = 1'b0;
        // Writes to 0, 1 and 2 fall through untouched
        if (REG_WR && REG_ADDR == `ACRB_ADDR_CONV_CTRL) begin
            fmt_nxt = REG_WDATA[`ACRB_CTRL_FMT_BIT];
            rbm_nxt = REG_WDATA[`ACRB_CTRL_RBM_HI:`ACRB_CTRL_RBM_LO];
            div_nxt = REG_WDATA[`ACRB_CTRL_DIV_HI:`ACRB_CTRL_DIV_LO];
        end else if (REG_WR && REG_ADDR == `ACRB_ADDR_GAIN_CHAN) begin
            gain_nxt = REG_WDATA[`ACRB_GC_GAIN_HI:`ACRB_GC_GAIN_LO];
            chan_nxt = REG_WDATA[`ACRB_GC_CHAN_HI:`ACRB_GC_CHAN_LO];
            start_req = REG_WDATA[`ACRB_GC_BUSY_BIT];
        end
        // Direct start wins over a same-cycle register write
        if (DIRECT_START) begin
            gain_nxt = DIRECT_BYTE[`ACRB_GC_GAIN_HI:`ACRB_GC_GAIN_LO];
            chan_nxt = DIRECT_BYTE[`ACRB_GC_CHAN_HI:`ACRB_GC_CHAN_LO];
            start_req = 1'b1;
        end
        if (cv_r == CV_RUN && SAR_DONE) begin
            // Core delivers two's complement; flipping the sign gives offset binary
            if (fmt_r) begin
                result_nxt = {~SAR_RESULT[RESULT_W-1], SAR_RESULT[RESULT_W-2:0]};
            end else begin
                result_nxt = SAR_RESULT;
            end
            range_nxt = cmp_s2_r;
        end
        ovr_nxt = |range_nxt;
    end

    // Start sequencer: wait two divided-clock falls, then run until done
    always_comb begin
        cv_nxt = cv_r;
        falls_nxt = falls_r;
        start_nxt = 1'b0;
        case (cv_r)
            CV_IDLE: begin
                if (start_req) begin
                    cv_nxt = CV_ARM;
                    falls_nxt = 2'h0;
                end
            end
            CV_ARM: begin
                if (divided_conv_clock_fall) begin
                    falls_nxt = 2'(falls_r + 2'h1);
                    if (2'(falls_r + 2'h1) == `ACRB_START_FALLS) begin
                        cv_nxt = CV_RUN;
                        start_nxt = 1'b1;
                    end
                end
            end
            CV_RUN: begin
                if (SAR_DONE) begin
                    cv_nxt = CV_IDLE;
                end
            end
            default: begin
                cv_nxt = CV_IDLE;
            end
        endcase
        busy_nxt = (cv_nxt != CV_IDLE);
    end

    // Automatic read-back after each finished conversion
    always_comb begin
        rb_nxt = rb_r;
        rb_low_first_nxt = rb_low_first_r;
        rb_valid_nxt = 1'b0;
        rb_data_nxt = rb_data_r;
        case (rb_r)
            RB_IDLE: begin
                if (cv_r == CV_RUN && SAR_DONE && rbm_r != `ACRB_RBM_EXPLICIT) begin
                    rb_nxt = (rbm_r == `ACRB_RBM_HIGH_ONLY) ? RB_SECOND : RB_FIRST;
                    // High-only sets this too, so the second state sends the high byte
                    rb_low_first_nxt = rbm_r[1];
                end
            end
            RB_FIRST: begin
                rb_valid_nxt = 1'b1;
                rb_data_nxt = rb_low_first_r ? byte_lo : byte_hi;
                rb_nxt = RB_SECOND;
            end
            RB_SECOND: begin
                rb_valid_nxt = 1'b1;
                rb_data_nxt = rb_low_first_r ? byte_hi : byte_lo;
                rb_low_first_nxt = 1'b0;
                rb_nxt = RB_IDLE;
            end
            default: begin
                rb_nxt = RB_IDLE;
            end
        endcase
    end

    // Register read port
    always_comb begin
        rdata_nxt = rdata_r;
        if (REG_RD) begin
            if (REG_ADDR == `ACRB_ADDR_RESULT_LO) begin
                rdata_nxt = byte_lo;
            end else if (REG_ADDR == `ACRB_ADDR_RESULT_HI) begin
                rdata_nxt = byte_hi;
            end else if (REG_ADDR == `ACRB_ADDR_RANGE) begin
                rdata_nxt = {2'h0, range_r};
            end else if (REG_ADDR == `ACRB_ADDR_CONV_CTRL) begin
                rdata_nxt = {2'h0, fmt_r, 1'b0, rbm_r, div_r};
            end else if (REG_ADDR == `ACRB_ADDR_GAIN_CHAN) begin
                rdata_nxt = {busy_r, gain_r, chan_r};
            end else begin
                rdata_nxt = `ACRB_RESET_BYTE;
            end
        end
    end

    // Gain and input routing decode
    always_comb begin
        case (gain_nxt)
            3'h0: gfac_nxt = 5'h01;
            3'h1: gfac_nxt = 5'h02;
            3'h2: gfac_nxt = 5'h04;
            3'h3: gfac_nxt = 5'h05;
            3'h4: gfac_nxt = 5'h08;
            3'h5: gfac_nxt = 5'h0A;
            3'h6: gfac_nxt = 5'h10;
            default: gfac_nxt = 5'h14;
        endcase
        pos_nxt = 8'h00;
        neg_nxt = 8'h00;
        swap_nxt = chan_nxt[2] & ~chan_nxt[3];
        if (chan_nxt[3]) begin
            // Single-ended: negative side is system ground
            pos_nxt[chan_nxt[2:0]] = 1'b1;
        end else if (chan_nxt[2]) begin
            pos_nxt[{chan_nxt[1:0], 1'b1}] = 1'b1;
            neg_nxt[{chan_nxt[1:0], 1'b0}] = 1'b1;
        end else begin
            pos_nxt[{chan_nxt[1:0], 1'b0}] = 1'b1;
            neg_nxt[{chan_nxt[1:0], 1'b1}] = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            fmt_r <= 1'b0;
            rbm_r <= `ACRB_RBM_EXPLICIT;
            div_r <= 2'h0;
            gain_r <= 3'h0;
            chan_r <= 4'h0;
            result_r <= '0;
            range_r <= '0;
            rdata_r <= `ACRB_RESET_BYTE;
            cv_r <= CV_IDLE;
            falls_r <= 2'h0;
            start_r <= 1'b0;
            rb_r <= RB_IDLE;
            rb_low_first_r <= 1'b0;
            rb_valid_r <= 1'b0;
            rb_data_r <= 8'h00;
            gfac_r <= 5'h01;
            pos_r <= 8'h01;
            neg_r <= 8'h02;
            busy_r <= 1'b0;
            swap_r <= 1'b0;
            ovr_r <= 1'b0;
        end else begin
            fmt_r <= fmt_nxt;
            rbm_r <= rbm_nxt;
            div_r <= div_nxt;
            gain_r <= gain_nxt;
            chan_r <= chan_nxt;
            result_r <= result_nxt;
            range_r <= range_nxt;
            rdata_r <= rdata_nxt;
            cv_r <= cv_nxt;
            falls_r <= falls_nxt;
            start_r <= start_nxt;
            rb_r <= rb_nxt;
            rb_low_first_r <= rb_low_first_nxt;
            rb_valid_r <= rb_valid_nxt;
            rb_data_r <= rb_data_nxt;
            gfac_r <= gfac_nxt;
            pos_r <= pos_nxt;
            neg_r <= neg_nxt;
            busy_r <= busy_nxt;
            swap_r <= swap_nxt;
            ovr_r <= ovr_nxt;
        end
    end

    assign REG_RDATA = rdata_r;
    assign DIVIDED_CONV_CLOCK = divided_conv_clock;
    assign CONV_START = start_r;
    assign CONV_BUSY = busy_r;
    assign GAIN_CODE = gain_r;
    assign GAIN_FACTOR = gfac_r;
    assign CHANNEL_CODE = chan_r;
    assign SINGLE_ENDED_SEL = chan_r[3];
    assign POLARITY_SWAP = swap_r;
    assign POS_LINE_SEL = pos_r;
    assign NEG_LINE_SEL = neg_r;
    assign OUTPUT_FORMAT_SEL = fmt_r;
    assign OVER_RANGE_FLAG = ovr_r;
    assign READBACK_VALID = rb_valid_r;
    assign READBACK_DATA = rb_data_r;

endmodule : acrb_top

// *** verif/acrb_props.sv ***
`timescale 1ns/1ps
`include "acrb_regs.svh"

module acrb_props #(
    parameter int RESULT_W = `ACRB_RESULT_W
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [`ACRB_ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic DIRECT_START,
    input wire logic [7:0] DIRECT_BYTE,
    input wire logic CONVERTER_CLOCK_IN,
    input wire logic [RESULT_W-1:0] SAR_RESULT,
    input wire logic SAR_DONE,
    input wire logic [`ACRB_RANGE_W-1:0] RANGE_CMP,
    input wire logic DIVIDED_CONV_CLOCK,
    input wire logic CONV_START,
    input wire logic CONV_BUSY,
    input wire acrb_pkg::acrb_gain_t GAIN_CODE,
    input wire logic [4:0] GAIN_FACTOR,
    input wire acrb_pkg::acrb_chan_t CHANNEL_CODE,
    input wire logic SINGLE_ENDED_SEL,
    input wire logic POLARITY_SWAP,
    input wire logic [7:0] POS_LINE_SEL,
    input wire logic [7:0] NEG_LINE_SEL,
    input wire logic OUTPUT_FORMAT_SEL,
    input wire logic OVER_RANGE_FLAG,
    input wire logic READBACK_VALID,
    input wire logic [7:0] READBACK_DATA
);
    import acrb_pkg::*;

    localparam logic [4:0] GF [8] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h08, 5'h0A, 5'h10, 5'h14};

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    sequence s_wr_start;
        REG_WR && REG_ADDR == `ACRB_ADDR_GAIN_CHAN && REG_WDATA[7] && !DIRECT_START;
    endsequence
    // Start pulse lands while the divided clock is in its low phase
    sequence s_one_start;
        CONV_START && CONV_BUSY && !DIVIDED_CONV_CLOCK ##1 !CONV_START;
    endsequence

    property p_busy_on_start;
        s_wr_start ##0 !CONV_BUSY |=> CONV_BUSY;
    endproperty
    a_busy_on_start: assert property (p_busy_on_start) else $error("busy not raised");

    property p_busy_cause;
        $rose(CONV_BUSY) |-> $past(DIRECT_START) ||
            $past(REG_WR && REG_ADDR == `ACRB_ADDR_GAIN_CHAN && REG_WDATA[7]);
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without start");

    property p_start_pulse;
        CONV_START |-> s_one_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("bad start pulse");

    property p_done_ends;
        SAR_DONE && CONV_BUSY && !CONV_START |=> !CONV_BUSY;
    endproperty
    a_done_ends: assert property (p_done_ends) else $error("busy stuck");

    property p_gain;
        GAIN_FACTOR == GF[GAIN_CODE];
    endproperty
    a_gain: assert property (p_gain) else $error("gain factor wrong");

    property p_se_route;
        CHANNEL_CODE[3] |->
            SINGLE_ENDED_SEL && NEG_LINE_SEL == 8'h00 && POS_LINE_SEL == 8'h01 << CHANNEL_CODE[2:0];
    endproperty
    a_se_route: assert property (p_se_route) else $error("single-ended routing");

    property p_diff_route;
        !CHANNEL_CODE[3] |-> !SINGLE_ENDED_SEL && POLARITY_SWAP == CHANNEL_CODE[2] &&
            POS_LINE_SEL == 8'h01 << {CHANNEL_CODE[1:0], CHANNEL_CODE[2]} &&
            NEG_LINE_SEL == 8'h01 << {CHANNEL_CODE[1:0], !CHANNEL_CODE[2]};
    endproperty
    a_diff_route: assert property (p_diff_route) else $error("differential routing");

    property p_rb_cause;
        READBACK_VALID |-> $past(SAR_DONE, 2) || $past(SAR_DONE, 3);
    endproperty
    a_rb_cause: assert property (p_rb_cause) else $error("stray read-back byte");

    property p_ovr_cause;
        $changed(OVER_RANGE_FLAG) |-> $past(SAR_DONE) || $past(SAR_DONE, 2);
    endproperty
    a_ovr_cause: assert property (p_ovr_cause) else $error("over-range moved");

    property p_fmt;
        $changed(OUTPUT_FORMAT_SEL) |-> $past(REG_WR && REG_ADDR == `ACRB_ADDR_CONV_CTRL);
    endproperty
    a_fmt: assert property (p_fmt) else $error("format moved");

endmodule : acrb_props

// *** verif/acrb_core_model.sv ***
`timescale 1ns/1ps

module acrb_core_model (
    input wire logic clk,
    input wire logic start,
    input wire logic [11:0] res_in,
    input wire logic [5:0] rng_in,
    input wire logic [7:0] lat,
    output logic [11:0] sar_result,
    output logic sar_done,
    output logic [5:0] range_cmp
);
    initial begin
        sar_result = 12'h000;
        sar_done = 1'b0;
        range_cmp = 6'h00;
        forever begin
            @(posedge clk);
            if (start === 1'b1) begin
                @(negedge clk);
                // Levels settle well before the end pulse so the syncs catch them
                range_cmp = rng_in;
                repeat (lat) @(negedge clk);
                sar_result = res_in;
                sar_done = 1'b1;
                @(negedge clk);
                sar_done = 1'b0;
                // Stale data must not look valid
                sar_result = ~res_in;
            end
        end
    end
endmodule : acrb_core_model

// *** verif/adc_control_register_bank_bench.sv ***
`timescale 1ns/1ps
`include "acrb_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end

module adc_control_register_bank_bench;
    import acrb_pkg::*;
    logic CLK, RESETN, REG_WR, REG_RD, DIRECT_START, SAR_DONE;
    logic [4:0] REG_ADDR;
    logic [7:0] REG_WDATA, REG_RDATA, DIRECT_BYTE, POS_LINE_SEL, NEG_LINE_SEL, READBACK_DATA;
    logic CONVERTER_CLOCK_IN, DIVIDED_CONV_CLOCK, CONV_START, CONV_BUSY, SINGLE_ENDED_SEL;
    logic POLARITY_SWAP, OUTPUT_FORMAT_SEL, OVER_RANGE_FLAG, READBACK_VALID;
    logic [11:0] SAR_RESULT, nxt_res;
    logic [5:0] RANGE_CMP, nxt_rng;
    logic [4:0] GAIN_FACTOR;
    acrb_gain_t GAIN_CODE;
    acrb_chan_t CHANNEL_CODE;
    logic [7:0] lat;
    logic [2:0] ccnt = 3'h0;
    logic [7:0] rb_q[$];
    logic [7:0] exp_q[$];
    int n_fail, tests_run;
    int gtab[8] = '{1, 2, 4, 5, 8, 10, 16, 20};

    acrb_top #(.RESULT_W(12)) DUT (.CLK, .RESETN, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD,
        .REG_RDATA, .DIRECT_START, .DIRECT_BYTE, .CONVERTER_CLOCK_IN, .SAR_RESULT, .SAR_DONE,
        .RANGE_CMP, .DIVIDED_CONV_CLOCK, .CONV_START, .CONV_BUSY, .GAIN_CODE, .GAIN_FACTOR,
        .CHANNEL_CODE, .SINGLE_ENDED_SEL, .POLARITY_SWAP, .POS_LINE_SEL, .NEG_LINE_SEL,
        .OUTPUT_FORMAT_SEL, .OVER_RANGE_FLAG, .READBACK_VALID, .READBACK_DATA);

    acrb_core_model CORE (.clk(CLK), .start(CONV_START), .res_in(nxt_res), .rng_in(nxt_rng),
        .lat(lat), .sar_result(SAR_RESULT), .sar_done(SAR_DONE), .range_cmp(RANGE_CMP));

    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    // Pin clock of 8 system cycles keeps divide-by-1 at the converter ceiling
    assign CONVERTER_CLOCK_IN = ccnt[2];
    always @(negedge CLK) ccnt <= ccnt + 3'h1;

    always @(posedge CLK) if (READBACK_VALID === 1'b1) rb_q.push_back(READBACK_DATA);

    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop

    task wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge CLK);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1'b1;
        @(negedge CLK);
        REG_WR = 1'b0;
    endtask : wr

    task rd_chk(input logic [4:0] a, input logic [7:0] e);
        @(negedge CLK);
        REG_ADDR = a;
        REG_RD = 1'b1;
        @(negedge CLK);
        REG_RD = 1'b0;
        `CHK(REG_RDATA, e)
    endtask : rd_chk

    // Cycles between the second and third rises of the divided clock
    task dper(output int n);
        int c, e, t;
        logic p;
        e = 0;
        t = 0;
        p = DIVIDED_CONV_CLOCK;
        for (c = 0; c < 400 && e < 3; c++) begin
            @(posedge CLK);
            if (DIVIDED_CONV_CLOCK === 1'b1 && p === 1'b0) begin
                e++;
                if (e == 2) t = c;
                n = c - t;
            end
            p = DIVIDED_CONV_CLOCK;
        end
    endtask : dper

    initial begin
        repeat (60000) @(posedge CLK);
        n_fail++;
        report_and_stop();
    end

    initial begin
        int i, k, n;
        logic [7:0] v, hi, lo, a, b, g;
        logic [11:0] r;
        RESETN = 1'b0;
        REG_ADDR = 5'h00;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_WDATA = 8'h00;
        DIRECT_START = 1'b0;
        DIRECT_BYTE = 8'h00;
        nxt_res = 12'h000;
        nxt_rng = 6'h00;
        lat = 8'h03;
        n_fail = 0;
        tests_run = 0;
        void'($urandom(32'h0FD3));
        repeat (20) @(negedge CLK);
        RESETN = 1'b1;
        repeat (3) @(negedge CLK);
        `CHK(GAIN_FACTOR, 5'h01);
        for (i = 0; i < 6; i++) rd_chk((i == 5) ? 5'h1F : 5'(i), 8'h00);
        for (i = 0; i < 4; i++) begin
            v = 8'($urandom) & 8'h2F;
            wr(`ACRB_ADDR_CONV_CTRL, v);
            rd_chk(`ACRB_ADDR_CONV_CTRL, v);
            `CHK(OUTPUT_FORMAT_SEL, v[5]);
        end
        for (i = 0; i < 16; i++) begin
            v = {1'b0, 3'(i), 4'(i)};
            wr(`ACRB_ADDR_GAIN_CHAN, v);
            rd_chk(`ACRB_ADDR_GAIN_CHAN, v);
            `CHK(GAIN_FACTOR, 5'(gtab[i % 8]));
            `CHK(CHANNEL_CODE, v[3:0]);
        end
        for (i = 0; i < 4; i++) begin
            wr(`ACRB_ADDR_CONV_CTRL, 8'(i));
            dper(n);
            `CHK(n, 8 << i);
        end
        for (i = 0; i < 8; i++) begin
            wr(`ACRB_ADDR_CONV_CTRL, {2'b00, i[2], 1'b0, i[1:0], 2'b00});
            nxt_res = 12'($urandom);
            nxt_rng = i[0] ? 6'($urandom) : 6'h00;
            lat = (i < 4) ? 8'h03 : 8'h28;
            g = 8'($urandom) & 8'h7F;
            if (i[0]) begin
                @(negedge CLK);
                DIRECT_BYTE = g;
                DIRECT_START = 1'b1;
                @(negedge CLK);
                DIRECT_START = 1'b0;
            end else wr(`ACRB_ADDR_GAIN_CHAN, 8'h80 | g);
            rd_chk(`ACRB_ADDR_GAIN_CHAN, 8'h80 | g);
            r = nxt_res ^ {i[2], 11'h000};
            hi = r[11:4];
            lo = {r[3:0], 3'b000, |nxt_rng};
            if (i[1:0] == 2'h1) exp_q.push_back(hi);
            if (i[1:0] != 2'h0) exp_q.push_back(i[1:0] == 2'h3 ? hi : lo);
            if (i[1:0] == 2'h2) exp_q.push_back(hi);
            for (k = 0; k < 500 && CONV_BUSY !== 1'b0; k++) @(negedge CLK);
            repeat (4) @(negedge CLK);
            `CHK(rb_q.size(), exp_q.size());
            while (exp_q.size() > 0 && rb_q.size() > 0) begin
                a = rb_q.pop_front();
                b = exp_q.pop_front();
                `CHK(a, b);
            end
            rb_q.delete();
            exp_q.delete();
            rd_chk(`ACRB_ADDR_RESULT_HI, hi);
            rd_chk(`ACRB_ADDR_RANGE, {2'b00, nxt_rng});
            `CHK(OVER_RANGE_FLAG, |nxt_rng);
            rd_chk(`ACRB_ADDR_GAIN_CHAN, g);
        end
        wr(`ACRB_ADDR_RESULT_HI, 8'($urandom));
        wr(`ACRB_ADDR_RANGE, 8'hFF);
        rd_chk(`ACRB_ADDR_RESULT_HI, hi);
        rd_chk(`ACRB_ADDR_RANGE, {2'b00, nxt_rng});
        report_and_stop();
    end
endmodule : adc_control_register_bank_bench

bind acrb_top acrb_props #(.RESULT_W(RESULT_W)) u_props (.CLK, .RESETN, .REG_ADDR, .REG_WR,
    .REG_WDATA, .REG_RD, .REG_RDATA, .DIRECT_START, .DIRECT_BYTE, .CONVERTER_CLOCK_IN,
    .SAR_RESULT, .SAR_DONE, .RANGE_CMP, .DIVIDED_CONV_CLOCK, .CONV_START, .CONV_BUSY,
    .GAIN_CODE, .GAIN_FACTOR, .CHANNEL_CODE, .SINGLE_ENDED_SEL, .POLARITY_SWAP, .POS_LINE_SEL,
    .NEG_LINE_SEL, .OUTPUT_FORMAT_SEL, .OVER_RANGE_FLAG, .READBACK_VALID, .READBACK_DATA);
